// File: logic/pcfg_defines.vh
// Constants for the pre-driver configuration and protection block
// ----------------------------------------------------------------------
// ----------------------------------------------------------------------
`ifndef PCFG_DEFINES_VH
`define PCFG_DEFINES_VH

// ----------------------------------------------------------------------
// Store map
// ----------------------------------------------------------------------
`define PCFG_WORDS 6
`define PCFG_ADDR_RSVD_A 3'h0
`define PCFG_ADDR_RSVD_B 3'h1
`define PCFG_ADDR_DEAD 3'h2
`define PCFG_ADDR_BLANK 3'h3
`define PCFG_ADDR_PROT 3'h4
`define PCFG_ADDR_PORT 3'h5
// Factory values per word
`define PCFG_RST_RSVD_A 8'h00
`define PCFG_RST_RSVD_B 8'h07
`define PCFG_RST_DEAD 8'h60
`define PCFG_RST_BLANK 8'ha6
`define PCFG_RST_PROT 8'he0
`define PCFG_RST_PORT 8'hc0
// Field positions
`define PCFG_DMON_MSB 2
`define PCFG_DMON_LSB 0
`define PCFG_DEAD_MSB 7
`define PCFG_DEAD_LSB 5
`define PCFG_BOOST_BIT 3
`define PCFG_BLANK_MSB 7
`define PCFG_BLANK_LSB 6
`define PCFG_PWM_BIT 5
`define PCFG_GAIN_MSB 3
`define PCFG_GAIN_LSB 1
`define PCFG_REGBF_BIT 7
`define PCFG_DSBF_BIT 6
`define PCFG_DSCMP_BIT 5
`define PCFG_GSCMP_BIT 4
`define PCFG_CP_BIT 2
`define PCFG_SPIEN_BIT 7

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define PCFG_CLK_NS 20
`define PCFG_PULSE_MIN_NS 256000
`define PCFG_PULSE_MAX_NS 512000
// Pulse window in 20 ns clocks, sized to fit the 16-bit counter
`define PCFG_PULSE_MIN_CYC 16'd12800
`define PCFG_PULSE_MAX_CYC 16'd25600
`define PCFG_WRITE_CYC 8'd8

`endif

// File: logic/pcfg_predriver_config.v
// Configuration store, copy engine, SPI entry and bridge protection
`include "pcfg_defines.vh"

module pcfg_predriver_config #(
    parameter [15:0] PULSE_MIN_CYC = `PCFG_PULSE_MIN_CYC,
    parameter [15:0] PULSE_MAX_CYC = `PCFG_PULSE_MAX_CYC,
    parameter [7:0] WRITE_CYC = `PCFG_WRITE_CYC
) (
    input wire sys_clk_i,
    input wire rst_i,
    input wire enable_i,
    input wire vcc_ok_i,
    input wire [2:0] high_side_inputs_i,
    input wire [2:0] low_side_inputs_i,
    input wire err_i,
    input wire errors_pending_i,
    input wire eof_pending_i,
    input wire motor_supply_overvoltage_i,
    input wire drain_fault_i,
    input wire regulator_overvoltage_flag_i,
    input wire gate_undervolt_i,
    input wire spi_cs_n_i,
    input wire spi_sck_i,
    input wire spi_mosi_i,
    output reg err_o,
    output reg err_oe_n_o,
    output reg spi_miso_o,
    output reg bridge_en_o,
    output wire spi_mode_o,
    output reg report_motor_ov_o,
    output reg report_drain_o,
    output reg report_reg_ov_o,
    output reg report_gate_uv_o,
    output reg report_store_ded_o,
    output wire [2:0] dead_time_o,
    output wire [2:0] drain_monitor_threshold_o,
    output wire [1:0] blank_time_o,
    output wire pwm_fast_o,
    output wire [2:0] sense_amp_gain_o,
    output wire boost_reference_select_o,
    output wire charge_pump_enable_o,
    output wire drain_comparator_en_o,
    output wire gate_undervolt_comparator_en_o
);

    // ------------------------------------------------------------------
    // States and storage
    // ------------------------------------------------------------------
    localparam [4:0] S_INIT = 5'h01;
    localparam [4:0] S_COPY = 5'h02;
    localparam [4:0] S_NORM = 5'h04;
    localparam [4:0] S_SPI = 5'h08;
    localparam [4:0] S_FIN = 5'h10;
    localparam [2:0] LAST_IDX = 3'h5;

    reg [4:0] state;
    reg [12:0] store [0:`PCFG_WORDS-1];
    reg [7:0] work [0:`PCFG_WORDS-1];
    reg [2:0] idx;
    reg [7:0] busy_cnt;
    reg [15:0] pulse_cnt;
    reg pulse_armed;
    reg err_q;
    reg fault_latch;
    reg sck_q;
    reg [4:0] bit_cnt;
    reg [14:0] rx;
    reg [7:0] tx;
    reg [2:0] spi_addr;
    reg [7:0] init_word;
    reg [7:0] enc_in;
    reg [7:0] wr_data;
    integer k;

    wire [12:0] enc_cw;
    wire [7:0] rd_data;
    wire rd_double;
    wire [2:0] rd_addr;
    wire ack_fall;
    wire fault_set;
    wire entry_ok;
    wire sck_rise;
    wire sck_fall;
    wire [15:0] word_in;
    wire wr_hit;

    // ------------------------------------------------------------------
    // Working register fields
    // ------------------------------------------------------------------
    assign dead_time_o =
        work[`PCFG_ADDR_DEAD][`PCFG_DEAD_MSB:`PCFG_DEAD_LSB];
    assign boost_reference_select_o =
        work[`PCFG_ADDR_DEAD][`PCFG_BOOST_BIT];
    assign drain_monitor_threshold_o =
        work[`PCFG_ADDR_RSVD_B][`PCFG_DMON_MSB:`PCFG_DMON_LSB];
    assign blank_time_o =
        work[`PCFG_ADDR_BLANK][`PCFG_BLANK_MSB:`PCFG_BLANK_LSB];
    assign pwm_fast_o = work[`PCFG_ADDR_BLANK][`PCFG_PWM_BIT];
    assign sense_amp_gain_o =
        work[`PCFG_ADDR_BLANK][`PCFG_GAIN_MSB:`PCFG_GAIN_LSB];
    assign charge_pump_enable_o =
        work[`PCFG_ADDR_PROT][`PCFG_CP_BIT];
    assign drain_comparator_en_o =
        work[`PCFG_ADDR_PROT][`PCFG_DSCMP_BIT];
    assign gate_undervolt_comparator_en_o =
        work[`PCFG_ADDR_PROT][`PCFG_GSCMP_BIT];
    assign spi_mode_o = state[3];

    // ------------------------------------------------------------------
    // Code words in and out of the store
    // ------------------------------------------------------------------
    // One decoder serves both the copy engine and SPI reads
    assign rd_addr = (state == S_COPY) ? idx : spi_addr;

    pcfg_secded_enc u_enc (
        .data_i(enc_in),
        .cw_o(enc_cw)
    );

    pcfg_secded_dec u_dec (
        .cw_i((rd_addr > LAST_IDX) ? 13'h0000 : store[rd_addr]),
        .data_o(rd_data),
        .double_o(rd_double)
    );

    // Factory image used to seed the store after reset
    always @* begin
        case (idx)
            `PCFG_ADDR_RSVD_A: init_word = `PCFG_RST_RSVD_A;
            `PCFG_ADDR_RSVD_B: init_word = `PCFG_RST_RSVD_B;
            `PCFG_ADDR_DEAD: init_word = `PCFG_RST_DEAD;
            `PCFG_ADDR_BLANK: init_word = `PCFG_RST_BLANK;
            `PCFG_ADDR_PROT: init_word = `PCFG_RST_PROT;
            default: init_word = `PCFG_RST_PORT;
        endcase
    end

    // Serial enable may only drop through SPI, never rise again
    always @* begin
        wr_data = word_in[7:0];
        if (spi_addr == `PCFG_ADDR_PORT)
            wr_data[`PCFG_SPIEN_BIT] = word_in[`PCFG_SPIEN_BIT] &
                rd_data[`PCFG_SPIEN_BIT];
        enc_in = (state == S_INIT) ? init_word : wr_data;
    end

    // ------------------------------------------------------------------
    // Line events and fault decisions
    // ------------------------------------------------------------------
    assign ack_fall = err_q & ~err_i;
    // Motor overvoltage has no mask bit on purpose
    assign fault_set = motor_supply_overvoltage_i |
        (drain_fault_i & drain_comparator_en_o &
         work[`PCFG_ADDR_PROT][`PCFG_DSBF_BIT]) |
        (regulator_overvoltage_flag_i &
         work[`PCFG_ADDR_PROT][`PCFG_REGBF_BIT]);
    // Shared pins must show the standstill pattern during the pulse
    assign entry_ok = ~enable_i & ~errors_pending_i &
        (&high_side_inputs_i) & ~(|low_side_inputs_i) &
        work[`PCFG_ADDR_PORT][`PCFG_SPIEN_BIT];

    assign sck_rise = spi_sck_i & ~sck_q;
    assign sck_fall = ~spi_sck_i & sck_q;
    assign word_in = {rx, spi_mosi_i};
    assign wr_hit = sck_rise && bit_cnt == 5'd15 && rx[14] &&
        spi_addr <= LAST_IDX && busy_cnt == 8'h00;

    // ------------------------------------------------------------------
    // Protection latch and reports
    // ------------------------------------------------------------------
    // Set beats the acknowledge that lands in the same cycle
    always @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            fault_latch <= 1'b0;
            err_q <= 1'b1;
            report_motor_ov_o <= 1'b0;
            report_drain_o <= 1'b0;
            report_reg_ov_o <= 1'b0;
            report_gate_uv_o <= 1'b0;
        end else begin
            err_q <= err_i;
            if (fault_set)
                fault_latch <= 1'b1;
            else if (eof_pending_i && ack_fall)
                fault_latch <= 1'b0;
            report_motor_ov_o <= motor_supply_overvoltage_i;
            report_drain_o <= drain_fault_i & drain_comparator_en_o;
            report_reg_ov_o <= regulator_overvoltage_flag_i;
            report_gate_uv_o <= gate_undervolt_i &
                gate_undervolt_comparator_en_o;
        end
    end

    // Bridge gate: fault_set included so the first fault cycle already
    // blocks, not one cycle later through the latch
    always @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i)
            bridge_en_o <= 1'b0;
        else
            bridge_en_o <= (state == S_NORM) &
                ~fault_set & ~fault_latch &
                vcc_ok_i &
                enable_i;
    end

    // ------------------------------------------------------------------
    // Mode sequencer, store, copy engine
    // ------------------------------------------------------------------
    always @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state <= S_INIT;
            idx <= 3'h0;
            busy_cnt <= 8'h00;
            pulse_cnt <= 16'h0000;
            pulse_armed <= 1'b0;
            report_store_ded_o <= 1'b0;
            err_o <= 1'b0;
            err_oe_n_o <= 1'b1;
            for (k = 0; k < `PCFG_WORDS; k = k + 1) begin
                store[k] <= 13'h0000;
                work[k] <= 8'h00;
            end
        end else begin
            if (busy_cnt != 8'h00)
                busy_cnt <= busy_cnt - 8'h01;
            case (state)
                S_INIT: begin
                    store[idx] <= enc_cw;
                    if (idx == LAST_IDX) begin
                        idx <= 3'h0;
                        state <= S_COPY;
                    end else begin
                        idx <= idx + 3'h1;
                    end
                end
                S_COPY: begin
                    // One word per cycle, outputs stay blocked
                    work[idx] <= rd_data;
                    if (idx == 3'h0)
                        report_store_ded_o <= rd_double;
                    else if (rd_double)
                        report_store_ded_o <= 1'b1;
                    if (idx == LAST_IDX) begin
                        idx <= 3'h0;
                        state <= S_NORM;
                        err_oe_n_o <= 1'b1;
                    end else begin
                        idx <= idx + 3'h1;
                    end
                end
                S_NORM: begin
                    // Measure the low pulse; any broken condition restarts
                    if (!entry_ok) begin
                        pulse_cnt <= 16'h0000;
                        pulse_armed <= 1'b0;
                    end else if (!err_i) begin
                        if (err_q) begin
                            pulse_cnt <= 16'h0001;
                            pulse_armed <= 1'b1;
                        end else if (pulse_cnt <= PULSE_MAX_CYC) begin
                            pulse_cnt <= pulse_cnt + 16'h0001;
                        end
                    end else if (pulse_armed) begin
                        pulse_armed <= 1'b0;
                        pulse_cnt <= 16'h0000;
                        if (pulse_cnt >= PULSE_MIN_CYC &&
                            pulse_cnt <= PULSE_MAX_CYC)
                            state <= S_SPI;
                    end
                end
                S_SPI: begin
                    if (wr_hit) begin
                        store[spi_addr] <= enc_cw;
                        busy_cnt <= WRITE_CYC;
                    end
                    if (enable_i) begin
                        state <= S_FIN;
                        err_oe_n_o <= 1'b0;
                    end
                end
                S_FIN: begin
                    // Programming in flight completes before the copy
                    if (busy_cnt == 8'h00)
                        state <= S_COPY;
                end
                default: begin
                    state <= S_INIT;
                    idx <= 3'h0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // SPI slave: 16-bit frames, command byte then data byte
    // ------------------------------------------------------------------
    // Command bit 7 is write, bits 2:0 the address; MSB first, input
    // sampled on SCK rise, output changed on SCK fall
    always @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            sck_q <= 1'b0;
            bit_cnt <= 5'h00;
            rx <= 15'h0000;
            tx <= 8'h00;
            spi_addr <= 3'h0;
            spi_miso_o <= 1'b0;
        end else begin
            sck_q <= spi_sck_i;
            if (state != S_SPI || spi_cs_n_i) begin
                bit_cnt <= 5'h00;
                spi_miso_o <= 1'b0;
            end else begin
                if (sck_rise) begin
                    rx <= {rx[13:0], spi_mosi_i};
                    bit_cnt <= bit_cnt + 5'h01;
                    if (bit_cnt == 5'd7)
                        spi_addr <= {rx[1:0], spi_mosi_i};
                end
                if (sck_fall && bit_cnt == 5'd8) begin
                    // Read data: corrected word, zero past the map
                    spi_miso_o <= rd_data[7];
                    tx <= {rd_data[6:0], 1'b0};
                end else if (sck_fall && bit_cnt > 5'd8) begin
                    spi_miso_o <= tx[7];
                    tx <= {tx[6:0], 1'b0};
                end
            end
        end
    end

endmodule

// File: logic/pcfg_secded_dec.v
// SECDED decoder: corrects one flipped bit, flags two
module pcfg_secded_dec (
    input wire [12:0] cw_i,
    output reg [7:0] data_o,
    output reg double_o
);
    integer i;
    reg [3:0] syn;
    reg [12:0] fx;
    reg par;

    // Syndrome names the bad position; overall parity tells one from two
    always @* begin
        syn = 4'h0;
        fx = cw_i;
        par = ^cw_i;
        for (i = 1; i < 13; i = i + 1) begin
            if (cw_i[i])
                syn = syn ^ i[3:0];
        end
        if (par && syn != 4'h0 && syn < 4'hd)
            fx[syn] = ~fx[syn];
        double_o = (syn != 4'h0) && !par;
        data_o = {fx[12:9], fx[7:5], fx[3]};
    end
endmodule

// File: logic/pcfg_secded_enc.v
// SECDED encoder: 8 data bits into a 13-bit stored word
module pcfg_secded_enc (
    input wire [7:0] data_i,
    output reg [12:0] cw_o
);
    integer i;
    reg [3:0] syn;
    reg [12:0] cw;

    // Data at non-power-of-two positions, then Hamming and overall parity
    always @* begin
        syn = 4'h0;
        cw = {data_i[7:4], 1'b0, data_i[3:1], 1'b0, data_i[0], 3'b000};
        for (i = 1; i < 13; i = i + 1) begin
            if (cw[i])
                syn = syn ^ i[3:0];
        end
        cw[1] = syn[0];
        cw[2] = syn[1];
        cw[4] = syn[2];
        cw[8] = syn[3];
        cw[0] = ^cw[12:1];
        cw_o = cw;
    end
endmodule

// File: tb/pcfg_mcu_model.sv
// Controller model: enable, gate inputs, error line and serial pins
module pcfg_mcu_model (
    input wire logic sys_clk_i,
    input wire logic miso_i,
    output logic enable_o,
    output logic [2:0] hs_o,
    output logic [2:0] ls_o,
    output logic err_pull_o,
    output logic cs_n_o,
    output logic sck_o,
    output logic mosi_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle: running, no pins asserted, serial port deselected
    initial begin
        enable_o = 1'b1;
        hs_o = 3'h0;
        ls_o = 3'h0;
        err_pull_o = 1'b0;
        cs_n_o = 1'b1;
        sck_o = 1'b0;
        mosi_o = 1'b0;
    end
    // Gate pins change only here, never inside a frame
    task automatic gates(input logic en, input logic [2:0] hs, ls);
        @(posedge sys_clk_i);
        enable_o <= en;
        hs_o <= hs;
        ls_o <= ls;
    endtask
    // Pull the shared error line low for n clocks
    task automatic pulse(input int n);
        @(posedge sys_clk_i);
        err_pull_o <= 1'b1;
        repeat (n) @(posedge sys_clk_i);
        err_pull_o <= 1'b0;
    endtask
    // 16-bit frame, MSB first; gate pins left at standstill meanwhile
    task automatic xfer(input logic [15:0] cmd, output logic [7:0] rd);
        @(posedge sys_clk_i);
        cs_n_o <= 1'b0;
        for (int i = 15; i >= 0; i--) begin
            mosi_o <= cmd[i];
            repeat (3) @(posedge sys_clk_i);
            sck_o <= 1'b1;
            if (i < 8) rd[i] = miso_i;
            repeat (3) @(posedge sys_clk_i);
            sck_o <= 1'b0;
        end
        repeat (3) @(posedge sys_clk_i);
        cs_n_o <= 1'b1;
        mosi_o <= ~mosi_o; // Released line shows the inverse of the last bit sent
    endtask
endmodule

// File: tb/pcfg_predriver_config_properties.sv
// Checker for the pre-driver configuration and protection block
module pcfg_predriver_config_properties #(
    parameter [15:0] PULSE_MIN_CYC = 16'd20,
    parameter [15:0] PULSE_MAX_CYC = 16'd40,
    parameter [7:0] WRITE_CYC = 8'd8
) (
    input wire sys_clk_i,
    input wire rst_i,
    input wire enable_i,
    input wire vcc_ok_i,
    input wire [2:0] high_side_inputs_i,
    input wire [2:0] low_side_inputs_i,
    input wire motor_supply_overvoltage_i,
    input wire drain_fault_i,
    input wire regulator_overvoltage_flag_i,
    input wire gate_undervolt_i,
    input wire err_oe_n_o,
    input wire bridge_en_o,
    input wire spi_mode_o,
    input wire report_drain_o,
    input wire report_reg_ov_o,
    input wire report_gate_uv_o,
    input wire drain_comparator_en_o,
    input wire gate_undervolt_comparator_en_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // Bridge gating
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    AST_MOTOR_OV: assert property (
        motor_supply_overvoltage_i |=> !bridge_en_o)
        else $error("bridge on after motor overvoltage");
    AST_EN_LOW: assert property (
        !enable_i |=> !bridge_en_o)
        else $error("bridge on with enable low");
    AST_VCC_LOW: assert property (
        !vcc_ok_i |=> !bridge_en_o)
        else $error("bridge on with logic supply low");
    AST_BRIDGE_UP: assert property (
        $rose(bridge_en_o) |-> $past(enable_i) && $past(vcc_ok_i)
        && err_oe_n_o)
        else $error("bridge released with a cause still set");
    AST_SPI_OFF: assert property (
        spi_mode_o |-> !bridge_en_o)
        else $error("bridge on in serial mode");
    // ------------------------------------------------------------
    // Reports, mode entry and exit
    // ------------------------------------------------------------
    AST_REG_OV_RPT: assert property (
        regulator_overvoltage_flag_i |=> report_reg_ov_o)
        else $error("regulator overvoltage not reported");
    AST_DRAIN_MASK: assert property (
        drain_fault_i && !drain_comparator_en_o |=> !report_drain_o)
        else $error("drain fault reported while comparator off");
    AST_GATE_UV: assert property (
        $rose(report_gate_uv_o) |-> $past(gate_undervolt_i)
        && $past(gate_undervolt_comparator_en_o))
        else $error("gate undervoltage report without cause");
    AST_ENTRY: assert property (
        $rose(spi_mode_o) |-> !$past(enable_i, 2)
        && $past(high_side_inputs_i, 2) == 3'h7
        && $past(low_side_inputs_i, 2) == 3'h0)
        else $error("serial mode entered without pin conditions");
    AST_EXIT_ERR: assert property (
        $rose(enable_i) && spi_mode_o |=> !err_oe_n_o [*3])
        else $error("error line not held low on mode exit");
    cover property ($rose(spi_mode_o));
    cover property ($rose(bridge_en_o));
    cover property ($rose(report_drain_o));
endmodule

bind pcfg_predriver_config pcfg_predriver_config_properties #(
    .PULSE_MIN_CYC(PULSE_MIN_CYC), .PULSE_MAX_CYC(PULSE_MAX_CYC),
    .WRITE_CYC(WRITE_CYC)) u_props (.*);

// File: tb/test_predriver_config_protection.sv
// Testbench for the pre-driver configuration and protection block
module test_predriver_config_protection;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk_i = 0, rst_i = 1, vcc_ok_i = 1, errors_pending_i = 0;
    logic eof_pending_i = 0, motor_supply_overvoltage_i = 0;
    logic drain_fault_i = 0, regulator_overvoltage_flag_i = 0;
    logic gate_undervolt_i = 0, err_pull, enable_i, spi_cs_n_i;
    logic spi_sck_i, spi_mosi_i, err_o, err_oe_n_o, spi_miso_o;
    logic bridge_en_o, spi_mode_o, report_motor_ov_o, report_drain_o;
    logic report_reg_ov_o, report_gate_uv_o, report_store_ded_o;
    logic [2:0] high_side_inputs_i, low_side_inputs_i, dead_time_o;
    logic [2:0] drain_monitor_threshold_o, sense_amp_gain_o;
    logic [1:0] blank_time_o;
    logic pwm_fast_o, boost_reference_select_o, charge_pump_enable_o;
    logic drain_comparator_en_o, gate_undervolt_comparator_en_o;
    logic [7:0] rd;
    int err_total = 0, check_count = 0, cyc = 0;
    // Rows: {en,vcc,mov,drn,rov,guv} -> {bridge,reports m/d/r/g}
    logic [10:0] rows [6] = '{
        11'b110001_10000,
        11'b010000_00000,
        11'b100000_00000,
        11'b111000_01000,
        11'b110100_00100,
        11'b110010_00010};
    // Wired-AND error line with pull-up
    wire err_i = !(err_pull || !err_oe_n_o);
    pcfg_predriver_config #(.PULSE_MIN_CYC(16'd20),
        .PULSE_MAX_CYC(16'd40)) dut (.*);
    pcfg_mcu_model mdl (.sys_clk_i(sys_clk_i), .miso_i(spi_miso_o),
        .enable_o(enable_i), .hs_o(high_side_inputs_i),
        .ls_o(low_side_inputs_i), .err_pull_o(err_pull),
        .cs_n_o(spi_cs_n_i), .sck_o(spi_sck_i), .mosi_o(spi_mosi_i));
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    initial forever #10 sys_clk_i = ~sys_clk_i;
    task automatic chk(input string nm, input logic [16:0] ev, gv);
        check_count++;
        if (gv !== ev) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", nm, ev, gv);
        end
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // Bounded wait: copy plus gating takes well under 40 clocks
    task automatic wait_bridge;
        for (int n = 0; n < 40 && bridge_en_o !== 1'b1; n++)
            @(posedge sys_clk_i);
        #1;
    endtask
    // Hang guard, far above the few hundred clocks used
    always @(posedge sys_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            finish_test();
        end
    end
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (10) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        repeat (5) @(posedge sys_clk_i);
        #1 chk("bridge_init", 1'b0, bridge_en_o);
        wait_bridge();
        chk("bridge_up", 1'b1, bridge_en_o);
        chk("defaults", {3'b011, 3'b111, 2'b10, 1'b1, 3'b011, 4'b0010,
            1'b0}, {dead_time_o, drain_monitor_threshold_o, blank_time_o,
            pwm_fast_o, sense_amp_gain_o, boost_reference_select_o,
            charge_pump_enable_o, drain_comparator_en_o,
            gate_undervolt_comparator_en_o, report_store_ded_o});
        $display("reset test done");
        // Each row: apply, release, then acknowledge end of frame
        for (int r = 0; r < 6; r++) begin
            mdl.gates(rows[r][10], 3'h0, 3'h0);
            {vcc_ok_i, motor_supply_overvoltage_i, drain_fault_i,
                regulator_overvoltage_flag_i, gate_undervolt_i}
                <= rows[r][9:5];
            repeat (2) @(posedge sys_clk_i);
            #1 chk("row", rows[r][4:0], {bridge_en_o, report_motor_ov_o,
                report_drain_o, report_reg_ov_o, report_gate_uv_o});
            mdl.gates(1'b1, 3'h0, 3'h0);
            {vcc_ok_i, motor_supply_overvoltage_i, drain_fault_i,
                regulator_overvoltage_flag_i, gate_undervolt_i} <= 5'h10;
            repeat (3) @(posedge sys_clk_i);
            #1 chk("row_hold", rows[r][8:6] == 0, bridge_en_o);
            @(posedge sys_clk_i);
            eof_pending_i <= 1'b1;
            mdl.pulse(2);
            eof_pending_i <= 1'b0;
            wait_bridge();
            chk("row_ack", 1'b1, bridge_en_o);
        end
        $display("table test done");
        // Pending errors block entry; short pulse refused, legal enters
        mdl.gates(1'b0, 3'h7, 3'h0);
        errors_pending_i <= 1'b1;
        mdl.pulse(30);
        repeat (4) @(posedge sys_clk_i);
        #1 chk("pending", 1'b0, spi_mode_o);
        @(posedge sys_clk_i);
        errors_pending_i <= 1'b0;
        mdl.pulse(10);
        repeat (4) @(posedge sys_clk_i);
        #1 chk("short_pulse", 1'b0, spi_mode_o);
        mdl.pulse(30);
        repeat (4) @(posedge sys_clk_i);
        #1 chk("entry", 1'b1, spi_mode_o);
        mdl.xfer(16'h8410, rd);
        repeat (10) @(posedge sys_clk_i);
        mdl.xfer(16'h0400, rd);
        chk("rd_prot", 8'h10, rd);
        mdl.xfer(16'h0500, rd);
        chk("rd_port", 8'hc0, rd);
        mdl.gates(1'b1, 3'h0, 3'h0);
        repeat (2) @(posedge sys_clk_i);
        #1 chk("exit", 3'b000, {err_oe_n_o, err_o, bridge_en_o});
        wait_bridge();
        chk("reload", 3'b101, {err_oe_n_o, drain_comparator_en_o,
            gate_undervolt_comparator_en_o});
        $display("serial test done");
        // Masked faults leave bridge on; motor overvoltage never masked
        @(posedge sys_clk_i);
        {drain_fault_i, regulator_overvoltage_flag_i, gate_undervolt_i}
            <= 3'b111;
        repeat (2) @(posedge sys_clk_i);
        #1 chk("masked", 4'b1011, {bridge_en_o, report_drain_o,
            report_reg_ov_o, report_gate_uv_o});
        @(posedge sys_clk_i);
        motor_supply_overvoltage_i <= 1'b1;
        repeat (2) @(posedge sys_clk_i);
        #1 chk("motor_ov", 1'b0, bridge_en_o);
        $display("mask test done");
        finish_test();
    end
endmodule
